// ---- rtl/icc_ctrl_regs.sv ----
// interrupt control configuration registers behind a zero-wait apb slave,
// with the decoded mode outputs, proximity timer start and edge detect.
// assumes irq_taken and group priority come from logic on the same clock;
// external interrupt lines are asynchronous pins.
`timescale 1ns/1ps

module icc_ctrl_regs (
  input  wire logic                          CLK_I,
  input  wire logic                          RST_N_I,
  input  wire logic                          PSEL_I,
  input  wire logic                          PENABLE_I,
  input  wire logic                          PWRITE_I,
  input  wire logic [icc_pkg::ADDR_W-1:0]    PADDR_I,
  input  wire logic [31:0]                   PWDATA_I,
  output logic      [31:0]                   PRDATA_O,
  output logic                               PREADY_O,
  output logic                               PSLVERR_O,
  input  wire logic                          IRQ_TAKEN_I,
  input  wire logic [icc_pkg::THR_W-1:0]     GROUP_PRIO_I,
  input  wire logic [icc_pkg::N_EXT-1:0]     EXT_IRQ_I,
  output icc_pkg::icc_cfg_t                  CFG_O,
  output logic      [31:0]                   SRC_PRIO_O,
  output logic      [icc_pkg::VOFF_W-1:0]    VECTOR_OFFSET_O,
  output logic                               PROX_START_O,
  output logic      [icc_pkg::N_EXT-1:0]     EXT_EDGE_O
);
  import icc_pkg::*;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic [3:0]        blk;
  logic [1:0]        comp;
  logic              mapped;
  logic              setup;
  logic              access;
  logic              wr_ctrl;
  logic              wr_prio;
  logic              wr_voff;
  icc_op_t           op;
  logic [31:0]       ctrl_q;
  logic [31:0]       ctrl_next;
  logic [31:0]       prio_q;
  logic [31:0]       voff_q;

  assign blk    = PADDR_I[7:4];
  assign comp   = PADDR_I[3:2];
  assign mapped = (PADDR_I[1:0] == 2'h0) &&
                  (blk == BLK_CTRL || blk == BLK_PRIO || blk == BLK_VOFF);
  assign setup  = PSEL_I && !PENABLE_I;
  assign access = PSEL_I && PENABLE_I && PREADY_O;
  assign op     = icc_op_t'(comp);

  assign wr_ctrl = access && PWRITE_I && mapped && blk == BLK_CTRL;
  assign wr_prio = access && PWRITE_I && mapped && blk == BLK_PRIO;
  assign wr_voff = access && PWRITE_I && mapped && blk == BLK_VOFF;

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  // masks keep unimplemented bits at zero whatever the port does
  icc_atomic_reg #(.MASK(CTRL_MASK), .RESET(CTRL_RESET)) u_ctrl (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .wr_en_i (wr_ctrl),
    .op_i    (op),
    .wdata_i (PWDATA_I),
    .next_o  (ctrl_next),
    .value_o (ctrl_q)
  );

  icc_atomic_reg #(.MASK(PRIO_MASK), .RESET(PRIO_RESET)) u_prio (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .wr_en_i (wr_prio),
    .op_i    (op),
    .wdata_i (PWDATA_I),
    .next_o  (),
    .value_o (prio_q)
  );

  icc_atomic_reg #(.MASK(VOFF_MASK), .RESET(VOFF_RESET)) u_voff (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .wr_en_i (wr_voff),
    .op_i    (op),
    .wdata_i (PWDATA_I),
    .next_o  (),
    .value_o (voff_q)
  );

  assign SRC_PRIO_O      = prio_q;
  assign VECTOR_OFFSET_O = voff_q[VOFF_W-1:0];

  // ----------------------------------------------------------------------
  // apb answer: data and ready prepared in the setup cycle, zero wait
  // ----------------------------------------------------------------------
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  always_comb begin
    next_prdata  = 32'h00000000;
    next_pready  = setup;
    next_pslverr = setup && !mapped;
    if (setup && mapped && !PWRITE_I && comp == COMP_BASE) begin
      case (blk)
        BLK_CTRL: next_prdata = ctrl_q;
        BLK_PRIO: next_prdata = prio_q;
        BLK_VOFF: next_prdata = voff_q;
        default:  next_prdata = 32'h00000000;
      endcase
    end
    // companion ports read as zero; software must not rely on it
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PRDATA_O  <= 32'h00000000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PRDATA_O  <= next_prdata;
      PREADY_O  <= next_pready;
      PSLVERR_O <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------------
  // decoded configuration, taken from the next control value so that
  // it lines up with the register itself
  // ----------------------------------------------------------------------
  icc_cfg_t    next_cfg;
  logic [6:0]  spc_code;

  always_comb begin
    spc_code               = ctrl_next[SPC_LSB +: SPC_W];
    next_cfg.multi_vector  = ctrl_next[MODE_BIT];
    next_cfg.shadow_sel    = ctrl_next[SS_BIT];
    next_cfg.prox_thr      = ctrl_next[THR_LSB +: THR_W];
    next_cfg.edge_pol      = ctrl_next[EP_LSB +: N_EXT];
    next_cfg.spacing_rsvd  = 1'b0;
    case (spc_code)
      7'h40:   next_cfg.spacing_bytes = 10'h200;
      7'h20:   next_cfg.spacing_bytes = 10'h100;
      7'h10:   next_cfg.spacing_bytes = 10'h080;
      7'h08:   next_cfg.spacing_bytes = 10'h040;
      7'h04:   next_cfg.spacing_bytes = 10'h020;
      7'h02:   next_cfg.spacing_bytes = 10'h010;
      7'h01:   next_cfg.spacing_bytes = 10'h008;
      7'h00:   next_cfg.spacing_bytes = 10'h000;
      default: begin
        // reserved codes fall back to zero spacing and are flagged
        next_cfg.spacing_bytes = 10'h000;
        next_cfg.spacing_rsvd  = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // proximity timer start and external edge detection
  // ----------------------------------------------------------------------
  logic [N_EXT-1:0] ext_s1;
  logic [N_EXT-1:0] ext_s2;
  logic [N_EXT-1:0] ext_s3;
  logic             next_prox;
  logic [N_EXT-1:0] next_edge;

  always_comb begin
    // priority zero qualifies as well: a plain less-or-equal compare
    next_prox = IRQ_TAKEN_I && CFG_O.prox_thr != THR_OFF &&
                GROUP_PRIO_I <= CFG_O.prox_thr;
    // ext_s1 feeds only ext_s2; the detector looks at later stages
    next_edge = (ext_s2 & ~ext_s3 & CFG_O.edge_pol) |
                (~ext_s2 & ext_s3 & ~CFG_O.edge_pol);
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CFG_O        <= '0;
      PROX_START_O <= 1'b0;
      EXT_EDGE_O   <= '0;
      ext_s1       <= '0;
      ext_s2       <= '0;
      ext_s3       <= '0;
    end else begin
      CFG_O        <= next_cfg;
      PROX_START_O <= next_prox;
      EXT_EDGE_O   <= next_edge;
      ext_s1       <= EXT_IRQ_I;
      ext_s2       <= ext_s1;
      ext_s3       <= ext_s2;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_CLEAR_PORT: assert property (
    wr_ctrl && comp == COMP_CLEAR |=>
      ctrl_q == ($past(ctrl_q) & ~($past(PWDATA_I) & CTRL_MASK)))
    else $error("clear port did not clear written bits");

  AST_SET_PORT: assert property (
    wr_prio && comp == COMP_SET |=>
      prio_q == ($past(prio_q) | ($past(PWDATA_I) & PRIO_MASK)))
    else $error("set port did not set written bits");

  AST_TOGGLE_PORT: assert property (
    wr_voff && comp == COMP_TOGGLE |=>
      voff_q == ($past(voff_q) ^ ($past(PWDATA_I) & VOFF_MASK)))
    else $error("invert port did not toggle written bits");

  AST_BASE_OFFSETS: assert property (
    access && PWRITE_I && PADDR_I == 8'h08 |=> prio_q == $past(prio_q))
    else $error("control set port disturbed another register");

  AST_SPACING_8: assert property (
    wr_ctrl && comp == COMP_BASE && PWDATA_I[22:16] == 7'h01 |=>
      CFG_O.spacing_bytes == 10'h008 && !CFG_O.spacing_rsvd)
    else $error("spacing code 0000001 not 8 bytes");

  AST_SPACING_512: assert property (
    wr_ctrl && comp == COMP_BASE && PWDATA_I[22:16] == 7'h40 |=>
      CFG_O.spacing_bytes == 10'h200)
    else $error("spacing code 1000000 not 512 bytes");

  AST_SHADOW: assert property (
    wr_ctrl && comp == COMP_SET && PWDATA_I[16] |=> CFG_O.shadow_sel)
    else $error("shadow select not presented");

  AST_MODE: assert property (
    wr_ctrl && comp == COMP_TOGGLE && PWDATA_I[12] |=>
      CFG_O.multi_vector != $past(CFG_O.multi_vector))
    else $error("vector mode did not follow register");

  AST_PROX_START: assert property (
    IRQ_TAKEN_I && CFG_O.prox_thr != 3'h0 && GROUP_PRIO_I <= CFG_O.prox_thr
      |=> PROX_START_O)
    else $error("proximity timer not started");

  AST_PROX_OFF: assert property (
    CFG_O.prox_thr == 3'h0 |=> !PROX_START_O)
    else $error("disabled proximity timer started");

  AST_UNIMPL_ZERO: assert property (
    setup && !PWRITE_I && PADDR_I == 8'h00 |=> (PRDATA_O & ~CTRL_MASK) == 32'h0)
    else $error("unimplemented control bits read nonzero");

  AST_RESET_ZERO: assert property (
    $rose(RST_N_I) |-> ctrl_q == 32'h0 && CFG_O == '0)
    else $error("control fields not zero after reset");

  AST_EDGE_RISE: assert property (
    ext_s2[0] && !ext_s3[0] && CFG_O.edge_pol[0] |=> EXT_EDGE_O[0])
    else $error("rising edge missed");

  AST_EDGE_FALL: assert property (
    !ext_s2[0] && ext_s3[0] && !CFG_O.edge_pol[0] |=> EXT_EDGE_O[0])
    else $error("falling edge missed");

  AST_READY: assert property (setup |=> PREADY_O ##1 !PREADY_O)
    else $error("ready not a single access cycle");

  AST_SLVERR: assert property (
    setup && !mapped |=> PREADY_O && PSLVERR_O)
    else $error("unmapped access not flagged");

  AST_COMP_READ: assert property (
    setup && !PWRITE_I && comp != COMP_BASE |=> PRDATA_O == 32'h00000000)
    else $error("companion port read not zero");

  AST_SPACING_RSVD: assert property (
    wr_ctrl && comp == COMP_BASE && PWDATA_I[22:16] == 7'h03 |=>
      CFG_O.spacing_bytes == 10'h000 && CFG_O.spacing_rsvd)
    else $error("reserved spacing code not flagged");

  AST_EDGE_QUIET: assert property (
    ext_s2[0] == ext_s3[0] |=> !EXT_EDGE_O[0])
    else $error("edge reported on a still line");

  COV_CTRL_WRITE: cover property (wr_ctrl && comp == COMP_BASE);
  COV_PROX: cover property (PROX_START_O);
  COV_EDGE: cover property (EXT_EDGE_O != '0);
  COV_SLVERR: cover property (PREADY_O && PSLVERR_O);
  COV_RSVD_SPACING: cover property (CFG_O.spacing_rsvd);

endmodule // icc_ctrl_regs

// ---- rtl/icc_pkg.sv ----
// package of the interrupt control configuration registers: offsets, masks,
// reset values, field positions, companion port codes and carrier types.
// assumes a 32-bit apb with byte addresses and one clock.
package icc_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [3:0]  BLK_CTRL      = 4'h0;
  localparam logic [3:0]  BLK_PRIO      = 4'h1;
  localparam logic [3:0]  BLK_VOFF      = 4'h2;
  localparam logic [1:0]  COMP_BASE     = 2'h0;
  localparam logic [1:0]  COMP_CLEAR    = 2'h1;
  localparam logic [1:0]  COMP_SET      = 2'h2;
  localparam logic [1:0]  COMP_TOGGLE   = 2'h3;

  // ----------------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] CTRL_MASK     = 32'h007f171f;
  localparam logic [31:0] PRIO_MASK     = 32'h1f1f1f1f;
  localparam logic [31:0] VOFF_MASK     = 32'h0003ffff;
  localparam logic [31:0] CTRL_RESET    = 32'h00000000;
  localparam logic [31:0] PRIO_RESET    = 32'h00000000;
  localparam logic [31:0] VOFF_RESET    = 32'h00000000;

  // ----------------------------------------------------------------------
  // field positions of the control register
  // ----------------------------------------------------------------------
  localparam int          SPC_LSB       = 16;
  localparam int          SPC_W         = 7;
  localparam int          SS_BIT        = 16;
  localparam int          MODE_BIT      = 12;
  localparam int          THR_LSB       = 8;
  localparam int          THR_W         = 3;
  localparam int          EP_LSB        = 0;
  localparam int          N_EXT         = 5;
  localparam int          VOFF_W        = 18;
  localparam int          SPACING_W     = 10;
  localparam logic [2:0]  THR_OFF       = 3'h0;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ICC_OP_WRITE,
    ICC_OP_CLEAR,
    ICC_OP_SET,
    ICC_OP_TOGGLE
  } icc_op_t;

  typedef struct packed {
    logic                 multi_vector;
    logic                 shadow_sel;
    logic [SPACING_W-1:0] spacing_bytes;
    logic                 spacing_rsvd;
    logic [THR_W-1:0]     prox_thr;
    logic [N_EXT-1:0]     edge_pol;
  } icc_cfg_t;

endpackage

// ---- rtl/icc_atomic_reg.sv ----
// one 32-bit register with plain write, clear, set and invert ports.
// assumes the caller gives a one-cycle write enable and the port code.
`timescale 1ns/1ps

module icc_atomic_reg #(
  parameter logic [31:0] MASK  = 32'hffffffff,
  parameter logic [31:0] RESET = 32'h00000000
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            wr_en_i,
  input  icc_pkg::icc_op_t     op_i,
  input  wire logic [31:0]     wdata_i,
  output logic      [31:0]     next_o,
  output logic      [31:0]     value_o
);
  import icc_pkg::*;

  logic [31:0] bits;

  // ----------------------------------------------------------------------
  // next value: only implemented bits ever move
  // ----------------------------------------------------------------------
  always_comb begin
    bits   = wdata_i & MASK;
    next_o = value_o;
    if (wr_en_i) begin
      case (op_i)
        ICC_OP_WRITE:  next_o = bits;
        ICC_OP_CLEAR:  next_o = value_o & ~bits;
        ICC_OP_SET:    next_o = value_o | bits;
        ICC_OP_TOGGLE: next_o = value_o ^ bits;
        default:       next_o = value_o;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      value_o <= RESET;
    end else begin
      value_o <= next_o;
    end
  end

endmodule // icc_atomic_reg

// ---- test/icc_cpu_model.sv ----
// cpu-side partner: takes interrupts at a group priority and drives
// the external interrupt pins; assumes the block's own clock.
`timescale 1ns/1ps

module icc_cpu_model (
  input  wire logic                     clk_i,
  output logic                          irq_taken_o,
  output logic [icc_pkg::THR_W-1:0]     group_prio_o,
  output logic [icc_pkg::N_EXT-1:0]     ext_irq_o
);
  import icc_pkg::*;

  initial begin
    irq_taken_o  = 1'b0;
    group_prio_o = 3'h0;
    ext_irq_o    = 5'h00;
  end

  // priority is scrambled outside the pulse so a stale value never
  // passes for a qualified one
  task automatic take(input logic [THR_W-1:0] prio);
    @(posedge clk_i);
    irq_taken_o  <= 1'b1;
    group_prio_o <= prio;
    @(posedge clk_i);
    irq_taken_o  <= 1'b0;
    group_prio_o <= ~prio;
  endtask

  task automatic pins(input logic [N_EXT-1:0] v);
    @(posedge clk_i);
    ext_irq_o <= v;
  endtask
endmodule // icc_cpu_model

// ---- test/tb_top.sv ----
// self-checking bench of the interrupt control configuration registers.
// assumes a zero-wait apb slave and the cpu partner model.
`timescale 1ns/1ps

module tb_top;
  import icc_pkg::*;
  logic              clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic              taken, prox;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, src_prio, v;
  logic [THR_W-1:0]  gprio;
  logic [N_EXT-1:0]  ext_irq, ext_edge, acc;
  logic [VOFF_W-1:0] voff;
  icc_cfg_t          cfg;
  int                fail_count, samples_checked, i, t, p;

  icc_ctrl_regs u_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IRQ_TAKEN_I(taken), .GROUP_PRIO_I(gprio), .EXT_IRQ_I(ext_irq),
    .CFG_O(cfg), .SRC_PRIO_O(src_prio), .VECTOR_OFFSET_O(voff),
    .PROX_START_O(prox), .EXT_EDGE_O(ext_edge)
  );

  icc_cpu_model u_cpu (
    .clk_i(clk), .irq_taken_o(taken), .group_prio_o(gprio), .ext_irq_o(ext_irq)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rck(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, rd);
  endtask

  task automatic cfgchk(input logic [31:0] w);
    icc_cfg_t x;
    x = '0;
    x.multi_vector = w[12];
    x.shadow_sel   = w[16];
    x.prox_thr     = w[10:8];
    x.edge_pol     = w[4:0];
    for (int k = 0; k < 7; k++)
      if (w[22:16] == 7'(1 << k))
        x.spacing_bytes = 10'h008 << k;
    x.spacing_rsvd = (w[22:16] != 7'h00) && (x.spacing_bytes == 10'h000);
    chk("cfg", 32'(x), 32'(cfg));
  endtask

  // edge pulse lands three edges after the pin moves; five gives slack
  task automatic ext(input logic [4:0] pins, input logic [4:0] x);
    u_cpu.pins(pins);
    acc = 5'h00;
    repeat (5) begin
      @(posedge clk);
      #1;
      acc = acc | ext_edge;
    end
    chk("ext_edge", 32'(x), 32'(acc));
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk("cfg_rst", 32'h0, 32'(cfg));
    for (i = 0; i < 3; i++)
      rck("rst_val", 8'(i * 16), 32'h0);
    apb(1'b1, 8'h00, 32'hffffffff);
    rck("ctrl_all", 8'h00, 32'h007f171f);
    cfgchk(32'h007f171f);
    apb(1'b1, 8'h04, 32'h00001000);
    rck("ctrl_clr", 8'h00, 32'h007f071f);
    apb(1'b1, 8'h08, 32'hffff1000);
    rck("ctrl_set", 8'h00, 32'h007f171f);
    apb(1'b1, 8'h0c, 32'h0000f01f);
    rck("ctrl_inv", 8'h00, 32'h007f0700);
    apb(1'b0, 8'h0c, 32'h0);
    for (i = 0; i < 9; i++) begin
      v = {9'h000, (i < 7) ? 7'(1 << i) : 7'(3 * (i - 7)), 3'h0, 1'(i), 1'b0,
           3'(i), 3'h0, 5'(i)};
      apb(1'b1, 8'h00, v);
      cfgchk(v);
    end
    for (t = 0; t < 8; t++) begin
      apb(1'b1, 8'h00, {21'h0, 3'(t), 8'h00});
      for (p = 0; p < 8; p++) begin
        u_cpu.take(3'(p));
        @(posedge clk);
        chk("prox", 32'(t != 0 && p <= t), 32'(prox));
      end
    end
    apb(1'b1, 8'h00, 32'h0000001f);
    ext(5'h01, 5'h01);
    ext(5'h00, 5'h00);
    apb(1'b1, 8'h04, 32'h0000001f);
    ext(5'h1e, 5'h00);
    ext(5'h00, 5'h1e);
    apb(1'b1, 8'h18, 32'hffffffff);
    apb(1'b1, 8'h14, 32'h00ff0000);
    rck("prio_clr", 8'h10, 32'h1f001f1f);
    chk("src_prio", 32'h1f001f1f, src_prio);
    apb(1'b1, 8'h28, 32'hffffffff);
    chk("voff_set", 32'h0003ffff, 32'(voff));
    apb(1'b1, 8'h2c, 32'h00030000);
    rck("voff_inv", 8'h20, 32'h0000ffff);
    apb(1'b1, 8'h30, 32'hffffffff);
    chk("err_unmapped", 32'h1, 32'(err));
    apb(1'b0, 8'h02, 32'h0);
    chk("err_unaligned", 32'h1, 32'(err));
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rck("ctrl_rerst", 8'h00, 32'h0);
    report_and_stop();
  end
endmodule // tb_top
